// ---- src/upf_pkg.sv ----
package upf_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // Timing figures in their natural units
    localparam int unsigned T_OVP_SUPPLY_NS = 2000;
    localparam int unsigned T_OVP_DATA_NS = 200;
    localparam int unsigned T_BLANK_MS = 2;
    localparam int unsigned T_RETRY_MS = 100;
    localparam int unsigned RECOVERY_INTERVAL_MS = 8;
    localparam int unsigned T_ON_MS = 13;
    // Cycle counts; longest times round down, least times round up
    localparam int unsigned OVP_SUPPLY_CYC = T_OVP_SUPPLY_NS * CLK_MHZ / 1000;
    localparam int unsigned OVP_DATA_CYC = T_OVP_DATA_NS * CLK_MHZ / 1000;
    localparam int unsigned BLANK_CYC = T_BLANK_MS * CLK_MHZ * 1000;
    localparam int unsigned RETRY_CYC = T_RETRY_MS * CLK_MHZ * 1000;
    localparam int unsigned RECV_CYC = RECOVERY_INTERVAL_MS * CLK_MHZ * 1000;
    localparam int unsigned ON_CYC = T_ON_MS * CLK_MHZ * 1000;
    localparam int unsigned TMR_W = 24;
    localparam int unsigned SYNC_W = 7;
    // Synchronised comparator vector bit positions
    localparam int unsigned B_OV_SUP = 0;
    localparam int unsigned B_OV_DP = 1;
    localparam int unsigned B_OV_DN = 2;
    localparam int unsigned B_SHORT = 3;
    localparam int unsigned B_OC = 4;
    localparam int unsigned B_UV = 5;
    localparam int unsigned B_HOT = 6;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h20;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_START = 3'b001,
        ST_NORMAL = 3'b010,
        ST_BLANK = 3'b011,
        ST_RETRY = 3'b100,
        ST_RECOVER = 3'b101
    } upf_state_t;
endpackage

// ---- src/upf_sync_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface upf_sync_if;
    import upf_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    modport src (output raw, input synced);
    modport snk (input raw, output synced);
endinterface
`default_nettype wire

// ---- src/upf_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module upf_sync
    import upf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Comparator levels in and out
    upf_sync_if.snk sif
);
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    logic [SYNC_W-1:0] nxt_meta;
    logic [SYNC_W-1:0] nxt_sync;

    // Safe reset value reads undervoltage so nothing turns on early
    always_comb begin
        nxt_meta = rst_n ? sif.raw : SYNC_RST;
        nxt_sync = rst_n ? meta_ff : SYNC_RST;
    end

    always_ff @(posedge clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign sif.synced = sync_ff;
endmodule // upf_sync
`default_nettype wire

// ---- src/upf_fault_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R01: Low connector supply enters short mode, fault
// R02: Supply back above short threshold releases fault
// R03: Overvoltage on any pin opens every switch
// R04: Overvoltage gone restores switches, releases fault
// R05: Overvoltage turnoff within supply/data response times
// R06: Overcurrent enters fault state, current limited
// R07: Persistent overcurrent: off for retry, retry
// R08: Current fine at retry resumes normal
// R09: Continuing overcurrent keeps retrying with fault
// R10: Overtemperature turns all off, fault, overrides
// R11: Enable high: switches off, fault low
// R12: Undervoltage: supply switch off, fault released
// R13: Switches on only enabled, powered, fault-free; data switch stays on through short and overcurrent faults
// R14: Normal host mode passes current, no fault
// R15: Data switches closed when enabled, no overvoltage
// R16: One fault output for all faults
// R17: Overcurrent fault within blanking time
// R18: Supply switch off at least retry time
// R19: Fault released after recovery interval
// R20: Fault released startup interval after enable
// R21: Cycle timers, synchronised inputs, thermal priority
module upf_fault_ctrl
    import upf_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC,
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,
    parameter int unsigned RECV_CYCLES = RECV_CYC,
    parameter int unsigned ON_CYCLES = ON_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control pin
    input wire logic enable_n,
    // Comparator results
    input wire logic ov_connector_supply,
    input wire logic ov_connector_data_pos,
    input wire logic ov_connector_data_neg,
    input wire logic connector_supply_below_short,
    input wire logic overcurrent,
    input wire logic system_supply_uvlo,
    input wire logic over_temperature,
    // Switch controls
    output logic supply_switch_on,
    output logic data_switch_on,
    output logic current_limit_on,
    output logic short_source_current,
    // Open-drain fault pin, enable low while driving low
    output logic fault_out_n_o,
    output logic fault_out_n_oe_n,
    // Status
    output logic [2:0] state_o
);
    upf_sync_if sif ();
    upf_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sif(sif)
    );

    logic en_meta_ff;
    logic en_ff;
    logic nxt_en_meta;
    logic nxt_en;

    // Comparators pass two flops before any use (see R21)
    assign sif.raw = {over_temperature, system_supply_uvlo, overcurrent,
                      connector_supply_below_short, ov_connector_data_neg,
                      ov_connector_data_pos, ov_connector_supply};

    always_comb begin
        nxt_en_meta = rst_n ? enable_n : 1'b1;
        nxt_en = rst_n ? en_meta_ff : 1'b1;
    end

    always_ff @(posedge clk) begin
        en_meta_ff <= nxt_en_meta;
        en_ff <= nxt_en;
    end

    logic ov_sup;
    logic ov_data;
    logic ov_any;
    logic short_c;
    logic oc;
    logic uv;
    logic hot;
    logic enabled;
    assign ov_sup = sif.synced[B_OV_SUP];
    assign ov_data = sif.synced[B_OV_DP] | sif.synced[B_OV_DN];
    assign ov_any = ov_sup | ov_data;
    assign short_c = sif.synced[B_SHORT];
    assign oc = sif.synced[B_OC];
    assign uv = sif.synced[B_UV];
    assign hot = sif.synced[B_HOT];
    assign enabled = ~en_ff;

    function automatic logic tmr_done(input logic [TMR_W-1:0] t,
                                      input int unsigned lim);
        tmr_done = (t >= TMR_W'(lim - 1));
    endfunction

    upf_state_t state_ff;
    upf_state_t nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;

    // Overvoltage and thermal are not sequenced states: they gate the
    // switches directly so the turnoff path is one flop long.
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_ff + TMR_W'(1);
        if (!rst_n) begin
            nxt_state = ST_OFF;
            nxt_tmr = '0;
        end else if (hot || !enabled || uv) begin
            // Leaving via off restarts the enable-on sequence (see R10)
            nxt_state = ST_OFF;
            nxt_tmr = '0;
        end else begin
            unique case (state_ff)
                ST_OFF: begin
                    nxt_state = ST_START;
                    nxt_tmr = '0;
                end
                ST_START: begin
                    if (tmr_done(tmr_ff, ON_CYCLES)) begin // see R20
                        nxt_state = ST_NORMAL;
                        nxt_tmr = '0;
                    end
                end
                ST_NORMAL: begin
                    nxt_tmr = '0;
                    if (oc && !ov_any) begin // see R06
                        nxt_state = ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    if (!oc) begin
                        nxt_state = ST_NORMAL;
                        nxt_tmr = '0;
                    end else if (tmr_done(tmr_ff, BLANK_CYCLES)) begin
                        nxt_state = ST_RETRY; // see R07 R17
                        nxt_tmr = '0;
                    end
                end
                ST_RETRY: begin
                    if (tmr_done(tmr_ff, RETRY_CYCLES)) begin // see R18
                        nxt_state = ST_RECOVER;
                        nxt_tmr = '0;
                    end
                end
                ST_RECOVER: begin
                    if (oc) begin
                        // Load still bad: blank again, then off (see R09)
                        nxt_state = ST_BLANK;
                        nxt_tmr = '0;
                    end else if (tmr_done(tmr_ff, RECV_CYCLES)) begin
                        nxt_state = ST_NORMAL; // see R08 R19
                        nxt_tmr = '0;
                    end
                end
                default: begin
                    nxt_state = ST_OFF;
                    nxt_tmr = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        state_ff <= nxt_state;
        tmr_ff <= nxt_tmr;
    end

    logic sup_ff;
    logic dat_ff;
    logic lim_ff;
    logic shrt_ff;
    logic flt_ff;
    logic hiz_ff;
    logic nxt_sup;
    logic nxt_dat;
    logic nxt_lim;
    logic nxt_shrt;
    logic nxt_flt;
    logic nxt_hiz;
    logic run;

    always_comb begin
        run = (state_ff != ST_OFF) && (state_ff != ST_RETRY);
        nxt_sup = 1'b0;
        nxt_dat = 1'b0;
        nxt_lim = 1'b0;
        nxt_shrt = 1'b0;
        nxt_flt = 1'b1;
        nxt_hiz = 1'b0;
        if (!rst_n) begin
            nxt_flt = 1'b0;
            nxt_hiz = 1'b1;
        end else if (hot) begin
            nxt_flt = 1'b1; // see R10 R21
        end else if (uv) begin
            nxt_hiz = 1'b1; // see R12
        end else if (!enabled) begin
            nxt_flt = 1'b1; // see R11
        end else if (ov_any) begin
            nxt_flt = 1'b1; // see R03 R05 R16
        end else begin
            // Supply switch follows state, data switch held on; release only after timers (see R13)
            nxt_sup = run && !(state_ff == ST_BLANK && tmr_done(tmr_ff,
                      BLANK_CYCLES));
            nxt_dat = 1'b1; // see R15 R04
            nxt_lim = (state_ff == ST_BLANK) || (state_ff == ST_RECOVER);
            nxt_shrt = short_c && run; // see R01
            nxt_flt = (state_ff != ST_NORMAL) || short_c; // see R02 R14
            nxt_hiz = !nxt_flt;
        end
    end

    always_ff @(posedge clk) begin
        sup_ff <= nxt_sup;
        dat_ff <= nxt_dat;
        lim_ff <= nxt_lim;
        shrt_ff <= nxt_shrt;
        flt_ff <= nxt_flt;
        hiz_ff <= nxt_hiz;
    end

    assign supply_switch_on = sup_ff;
    assign data_switch_on = dat_ff;
    assign current_limit_on = lim_ff;
    assign short_source_current = shrt_ff;
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe_n = hiz_ff || !flt_ff;
    assign state_o = state_ff;

    // Sequencer free to act: enabled, powered and cool
    logic live;
    assign live = enabled && !uv && !hot;

    // Input-to-output latency is three edges: two sync, one output flop
    a_ovp_turnoff: assert property ( // see R03
        @(posedge clk) disable iff (!rst_n)
        (sif.synced[B_OV_SUP] && !sif.synced[B_UV]) |=>
        !supply_switch_on && !data_switch_on)
        else $error("switch not off after overvoltage");

    a_ovp_fault: assert property ( // see R16
        @(posedge clk) disable iff (!rst_n)
        (ov_data && !uv) |=> !fault_out_n_oe_n)
        else $error("fault not driven on data overvoltage");

    a_hot_off: assert property ( // see R10
        @(posedge clk) disable iff (!rst_n)
        hot |=> (!supply_switch_on && !data_switch_on && !fault_out_n_oe_n))
        else $error("thermal shutdown not honoured");

    a_uv_hiz: assert property ( // see R12
        @(posedge clk) disable iff (!rst_n)
        (uv && !hot) |=> (fault_out_n_oe_n && !supply_switch_on))
        else $error("undervoltage output wrong");

    a_dis_off: assert property ( // see R11
        @(posedge clk) disable iff (!rst_n)
        (en_ff && !uv) |=> (!data_switch_on && !fault_out_n_oe_n))
        else $error("disabled device not off");

    a_short_flt: assert property ( // see R01
        @(posedge clk) disable iff (!rst_n)
        (short_c && enabled && !uv && !hot) |=> !fault_out_n_oe_n)
        else $error("short without fault");

    a_retry_off: assert property ( // see R18
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RETRY && $past(state_ff) == ST_BLANK) |->
        !supply_switch_on ##1 (!supply_switch_on)[*8])
        else $error("supply back on too early in retry");

    a_blank_bound: assert property ( // see R17
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_BLANK) |-> tmr_ff < TMR_W'(BLANK_CYCLES))
        else $error("blanking overran");

    a_normal_rel: assert property ( // see R14
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_NORMAL && !short_c && !ov_any && !hot && !uv &&
         enabled) |=> (fault_out_n_oe_n && supply_switch_on))
        else $error("normal mode not clean");

    a_data_on: assert property ( // see R15
        @(posedge clk) disable iff (!rst_n)
        (live && !ov_any) |=> data_switch_on)
        else $error("data switches not closed");

    a_ovp_restore: assert property ( // see R04
        @(posedge clk) disable iff (!rst_n)
        ($fell(ov_any) && live && state_ff == ST_NORMAL) |=>
        (data_switch_on && supply_switch_on))
        else $error("switches not restored after overvoltage");

    a_short_src: assert property ( // see R01
        @(posedge clk) disable iff (!rst_n)
        (short_c && run && live && !ov_any) |=> short_source_current)
        else $error("short current not sourced");

    a_oc_enter: assert property ( // see R06
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_NORMAL && oc && live && !ov_any) |=>
        (state_ff == ST_BLANK))
        else $error("overcurrent not taken");

    a_blank_fault: assert property ( // see R17
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_BLANK && oc && live &&
         tmr_ff == TMR_W'(BLANK_CYCLES - 1)) |=>
        (state_ff == ST_RETRY && !supply_switch_on && !fault_out_n_oe_n))
        else $error("blanking end did not shut off");

    a_retry_end: assert property ( // see R07
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RETRY && live &&
         tmr_ff == TMR_W'(RETRY_CYCLES - 1)) |=> (state_ff == ST_RECOVER))
        else $error("retry interval not ended");

    a_recover_on: assert property ( // see R07
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RECOVER && live && !ov_any) |=> supply_switch_on)
        else $error("supply not retried");

    a_recover_flt: assert property ( // see R19
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RECOVER && !uv) |=> !fault_out_n_oe_n)
        else $error("fault released before recovery end");

    a_recover_end: assert property ( // see R08
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RECOVER && !oc && live &&
         tmr_ff == TMR_W'(RECV_CYCLES - 1)) |=> (state_ff == ST_NORMAL))
        else $error("recovery did not resume normal");

    a_retry_again: assert property ( // see R09
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_RECOVER && oc && live) |=> (state_ff == ST_BLANK))
        else $error("persistent overcurrent not retried");

    a_start_flt: assert property ( // see R20
        @(posedge clk) disable iff (!rst_n)
        (state_ff == ST_START && !uv) |=> !fault_out_n_oe_n)
        else $error("fault released during startup");

    a_on_gate: assert property ( // see R13
        @(posedge clk) disable iff (!rst_n)
        supply_switch_on |-> $past(live && !ov_any))
        else $error("supply on while not allowed");
endmodule // upf_fault_ctrl
`default_nettype wire

// ---- verif/upf_port_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module upf_port_model (
    // Fault pin drive from the block
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe_n,
    // Connector conditions requested by the bench
    input wire logic [4:0] cond,
    // Comparator levels and the pulled-up pin
    output logic [4:0] cmp,
    output logic fault_pin
);
    // Board pull-up wins whenever the pin is released
    assign fault_pin = fault_out_n_oe_n ? 1'b1 : fault_out_n_o;
    assign cmp = cond;
endmodule // upf_port_model
`default_nettype wire

// ---- verif/upf_fault_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module upf_fault_ctrl_tb;
    import upf_pkg::*;
    localparam int BL = 20, RT = 40, RC = 10, ON = 15;
    logic clk = 1'b0, rst_n = 1'b0, en_n = 1'b1, uv = 1'b0, hot = 1'b0;
    logic [4:0] c = 5'h00;
    logic [4:0] cmp;
    logic sup, dat, lim, shs, fo, foe, pin;
    logic [2:0] st;
    logic [31:0] lfsr = 32'h17c5;
    int n_errors = 0, comparisons = 0, cyc = 0, k = 0;

    always #4 clk = ~clk;

    upf_port_model pm (.fault_out_n_o(fo), .fault_out_n_oe_n(foe),
        .cond(c), .cmp(cmp), .fault_pin(pin));

    upf_fault_ctrl #(.BLANK_CYCLES(BL), .RETRY_CYCLES(RT),
        .RECV_CYCLES(RC), .ON_CYCLES(ON)) uut (
        .clk(clk), .rst_n(rst_n), .enable_n(en_n),
        .ov_connector_supply(cmp[0]), .ov_connector_data_pos(cmp[1]),
        .ov_connector_data_neg(cmp[2]),
        .connector_supply_below_short(cmp[3]), .overcurrent(cmp[4]),
        .system_supply_uvlo(uv), .over_temperature(hot),
        .supply_switch_on(sup), .data_switch_on(dat),
        .current_limit_on(lim), .short_source_current(shs),
        .fault_out_n_o(fo), .fault_out_n_oe_n(foe), .state_o(st));

    function automatic logic [31:0] nxt_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Settled {supply, data, pin} for static conditions in normal state
    function automatic logic [2:0] expect_out(input logic [4:0] cv);
        if (hot) return 3'b000;
        if (uv) return 3'b001;
        if (en_n || |cv[2:0]) return 3'b000;
        if (cv[3]) return 3'b110;
        return 3'b111;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic check_outs;
        chk(8'({sup, dat, pin}), 8'(expect_out(c)));
    endtask

    // Bounded wait; k holds the cycles spent
    task automatic wait_state(input logic [2:0] s);
        k = 0;
        while (st !== s && k < 400) begin
            tick(1);
            k++;
        end
        chk(8'(st), 8'(s));
    endtask

    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", comparisons,
            n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        tick(4);
        rst_n = 1'b1;
        en_n = 1'b0;
        tick(5);
        chk(8'(pin), 8'h00);
        wait_state(ST_NORMAL);
        chk(8'(k >= ON - 6), 8'h01);
        tick(1);
        check_outs();
        $display("test startup done");

        // Single pins first, then random mixes
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt_rand(lfsr);
            c = {2'b00, (i < 3) ? 3'(1 << i) : (lfsr[2:0] | 3'b001)};
            tick(3);
            check_outs();
            c = 5'h00;
            tick(3);
            check_outs();
        end
        $display("test overvoltage done");

        c = 5'h08;
        tick(3);
        check_outs();
        chk(8'(shs), 8'h01);
        c = 5'h00;
        tick(3);
        check_outs();
        chk(8'(shs), 8'h00);
        $display("test short done");

        c = 5'h10;
        tick(3);
        chk(8'(st), 8'(ST_BLANK));
        // Limit flag follows the state by one edge
        tick(1);
        chk(8'(lim), 8'h01);
        wait_state(ST_RETRY);
        chk(8'(k <= BL + 2), 8'h01);
        chk(8'({sup, pin}), 8'h00);
        wait_state(ST_RECOVER);
        chk(8'(k >= RT - 1), 8'h01);
        tick(1);
        chk(8'(sup), 8'h01);
        wait_state(ST_BLANK);
        wait_state(ST_RETRY);
        // Load heals during the off time, so the retry finds it clean
        c = 5'h00;
        wait_state(ST_RECOVER);
        tick(3);
        chk(8'(pin), 8'h00);
        chk(8'({sup, lim}), 8'h03);
        wait_state(ST_NORMAL);
        chk(8'(k >= RC - 6), 8'h01);
        tick(1);
        check_outs();
        $display("test overcurrent done");

        en_n = 1'b1;
        tick(3);
        check_outs();
        uv = 1'b1;
        tick(3);
        check_outs();
        hot = 1'b1;
        tick(3);
        check_outs();
        uv = 1'b0;
        en_n = 1'b0;
        c = 5'h01;
        tick(3);
        check_outs();
        hot = 1'b0;
        c = 5'h00;
        wait_state(ST_NORMAL);
        chk(8'(k >= ON), 8'h01);
        tick(1);
        check_outs();
        $display("test lockout done");
        stop_test();
    end
endmodule // upf_fault_ctrl_tb
`default_nettype wire
